// file: include/efcf_defines.vh
// constants shared by the client-side frame fifo pair
// How it works
// - byte moves only when valid and accept low
// - first marker on first byte, last on last
// - each direction stores 4096 bytes of frames
// - receive frames reach user only when good
// - bad received frames are discarded whole
// - receive user side with own sync reset
// - occupancy level is stored bytes over 256
// - receive overflow drops frame, raises overflow flag
// - keep dropping until enough space is read
// - transmit starts only after whole frame stored
// - hold first byte until ack, then stream
// - collision aborts the current transmit frame
// - retransmit with collision replays frame from start
// - transmit full deasserts the accept output
// - full without whole frame: overflow, accept, discard
// - transmit user side with own sync reset
`ifndef EFCF_DEFINES_VH
`define EFCF_DEFINES_VH

// ---------------------------------------------------------------------
// widths and depths
// ---------------------------------------------------------------------
`define EFCF_BYTE_W         8
`define EFCF_STORE_AW       12
`define EFCF_STORE_DEPTH    13'h1000
`define EFCF_TX_ROOM_USED   13'h0ffe
`define EFCF_RX_RESUME_USED 13'h0a00
`define EFCF_SKID_DEPTH     8
`define EFCF_SKID_AW        3

// ---------------------------------------------------------------------
// occupancy level field
// ---------------------------------------------------------------------
`define EFCF_LEVEL_SAT_BIT  12
`define EFCF_LEVEL_MSB      11
`define EFCF_LEVEL_LSB      8
`define EFCF_LEVEL_SAT      4'hf

// ---------------------------------------------------------------------
// stored word layout
// ---------------------------------------------------------------------
`define EFCF_EOF_BIT        8
`define EFCF_SOF_BIT        9

`endif

// file: logic/efcf_frame_store.v
// frame memory with commit, drop, release and rewind pointers
`timescale 1ns/100ps
`include "efcf_defines.vh"

module efcf_frame_store #(
    parameter DW = 9,
    parameter AW = 12
)(
    input  wire          clk,
    input  wire          rst,
    input  wire          srst,
    input  wire          wr_en,
    input  wire [DW-1:0] wr_data,
    input  wire          wr_commit,
    input  wire          wr_drop,
    input  wire          rd_en,
    input  wire          rd_release,
    input  wire          rd_rewind,
    output wire [DW-1:0] rd_data,
    output wire          rd_avail,
    output wire [AW:0]   used,
    output wire          full
);

    reg  [DW-1:0] mem [0:(1<<AW)-1];
    reg  [AW:0]   wr_ptr_q;
    reg  [AW:0]   cmt_ptr_q;
    reg  [AW:0]   rd_ptr_q;
    reg  [AW:0]   base_ptr_q;
    wire          wr_do;
    wire [AW:0]   wr_ptr_d;
    wire [AW:0]   rd_ptr_d;

    assign used     = wr_ptr_q - base_ptr_q;
    assign full     = used[AW];
    assign wr_do    = wr_en & ~full;
    assign wr_ptr_d = wr_ptr_q + {{AW{1'b0}}, wr_do};
    assign rd_ptr_d = rd_ptr_q + {{AW{1'b0}}, rd_en};
    assign rd_avail = (rd_ptr_q != cmt_ptr_q);
    assign rd_data  = mem[rd_ptr_q[AW-1:0]];

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (wr_do)
            mem[wr_ptr_q[AW-1:0]] <= wr_data;
    end

    // -----------------------------------------------------------------
    // pointers
    // -----------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_q   <= {(AW+1){1'b0}};
            cmt_ptr_q  <= {(AW+1){1'b0}};
            rd_ptr_q   <= {(AW+1){1'b0}};
            base_ptr_q <= {(AW+1){1'b0}};
        end
        else if (srst)
        begin
            wr_ptr_q   <= {(AW+1){1'b0}};
            cmt_ptr_q  <= {(AW+1){1'b0}};
            rd_ptr_q   <= {(AW+1){1'b0}};
            base_ptr_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (wr_drop)
                wr_ptr_q <= cmt_ptr_q;
            else
                wr_ptr_q <= wr_ptr_d;
            if (wr_commit)
                cmt_ptr_q <= wr_ptr_d;
            if (rd_rewind)
                rd_ptr_q <= base_ptr_q;
            else
                rd_ptr_q <= rd_ptr_d;
            if (rd_release)
                base_ptr_q <= rd_ptr_d;
        end
    end

endmodule // efcf_frame_store

// file: logic/efcf_skid_fifo.v
// small valid/ready word fifo
`timescale 1ns/100ps
`include "efcf_defines.vh"

module efcf_skid_fifo #(
    parameter W     = 10,
    parameter DEPTH = 8,
    parameter AW    = 3
)(
    input  wire         clk,
    input  wire         rst,
    input  wire         srst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg  [W-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0] wr_q;
    reg  [AW-1:0] rd_q;
    reg  [AW:0]   cnt_q;
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else if (srst)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule // efcf_skid_fifo

// file: logic/efcf_top.v
// client-side receive and transmit frame fifo pair
`timescale 1ns/100ps
`include "efcf_defines.vh"

module efcf_top (
    input  wire                    clk_sys,
    input  wire                    rst,
    input  wire                    receive_user_sync_reset,
    input  wire [`EFCF_BYTE_W-1:0] rx_mac_byte,
    input  wire                    rx_mac_byte_valid,
    input  wire                    rx_mac_frame_good,
    input  wire                    rx_mac_frame_bad,
    output reg  [`EFCF_BYTE_W-1:0] receive_user_byte_out,
    output reg                     receive_first_marker_low,
    output reg                     receive_last_marker_low,
    output reg                     receive_valid_out_low,
    input  wire                    receive_accept_in_low,
    output reg  [3:0]              rx_fifo_level,
    output reg                     rx_overflow,
    input  wire                    transmit_user_sync_reset,
    input  wire [`EFCF_BYTE_W-1:0] transmit_user_byte_in,
    input  wire                    transmit_first_marker_low,
    input  wire                    transmit_last_marker_low,
    input  wire                    transmit_valid_in_low,
    output reg                     transmit_accept_out_low,
    output reg  [3:0]              tx_fifo_level,
    output reg                     tx_overflow,
    output reg  [`EFCF_BYTE_W-1:0] tx_mac_byte,
    output reg                     tx_mac_byte_valid,
    input  wire                    tx_mac_ack,
    input  wire                    tx_mac_collision,
    input  wire                    tx_mac_retransmit
);

    localparam [1:0] TX_IDLE = 2'b00;
    localparam [1:0] TX_ACK  = 2'b01;
    localparam [1:0] TX_SEND = 2'b10;
    localparam [1:0] TX_SKIP = 2'b11;

    function [3:0] efcf_level;
        input [`EFCF_STORE_AW:0] used;
        begin
            if (used[`EFCF_LEVEL_SAT_BIT])
                efcf_level = `EFCF_LEVEL_SAT;
            else
                efcf_level = used[`EFCF_LEVEL_MSB:`EFCF_LEVEL_LSB];
        end
    endfunction

    // -----------------------------------------------------------------
    // receive write side
    // -----------------------------------------------------------------
    reg  [`EFCF_BYTE_W-1:0]  rx_hold_q;
    reg                      rx_hold_valid_q;
    reg                      rx_in_frame_q;
    reg                      rx_drop_q;
    reg                      rx_lock_q;
    wire [`EFCF_STORE_AW:0]  rx_used;
    wire                     rx_full;
    wire                     rx_rd_avail;
    wire [`EFCF_BYTE_W:0]    rx_rd_data;
    wire                     rx_end;
    wire                     rx_need;
    wire                     rx_ovf_now;
    wire                     rx_drop_now;
    wire                     rx_wr_en;
    wire                     rx_commit;
    wire                     rx_discard;

    assign rx_end      = rx_mac_frame_good | rx_mac_frame_bad;
    assign rx_need     = rx_hold_valid_q & (rx_mac_byte_valid | rx_mac_frame_good);
    assign rx_ovf_now  = rx_need & rx_full & ~rx_drop_q;
    assign rx_drop_now = rx_drop_q | rx_ovf_now;
    assign rx_wr_en    = rx_need & ~rx_drop_now & ~rx_mac_frame_bad;
    assign rx_commit   = rx_mac_frame_good & ~rx_drop_now;
    assign rx_discard  = rx_mac_frame_bad | (rx_end & rx_drop_now);

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_hold_q       <= {`EFCF_BYTE_W{1'b0}};
            rx_hold_valid_q <= 1'b0;
            rx_in_frame_q   <= 1'b0;
            rx_drop_q       <= 1'b0;
            rx_lock_q       <= 1'b0;
            rx_overflow     <= 1'b0;
        end
        else if (receive_user_sync_reset)
        begin
            rx_hold_q       <= {`EFCF_BYTE_W{1'b0}};
            rx_hold_valid_q <= 1'b0;
            rx_in_frame_q   <= 1'b0;
            rx_drop_q       <= 1'b0;
            rx_lock_q       <= 1'b0;
            rx_overflow     <= 1'b0;
        end
        else
        begin
            rx_overflow <= rx_ovf_now;
            if (rx_end)
            begin
                rx_hold_valid_q <= 1'b0;
                rx_in_frame_q   <= 1'b0;
                rx_drop_q       <= 1'b0;
                if (rx_ovf_now)
                    rx_lock_q <= 1'b1;
            end
            else if (rx_mac_byte_valid)
            begin
                rx_hold_q       <= rx_mac_byte;
                rx_hold_valid_q <= 1'b1;
                rx_in_frame_q   <= 1'b1;
                if (!rx_in_frame_q)
                begin
                    rx_drop_q <= rx_lock_q & (rx_used > `EFCF_RX_RESUME_USED);
                    rx_lock_q <= rx_lock_q & (rx_used > `EFCF_RX_RESUME_USED);
                end
                else if (rx_ovf_now)
                begin
                    rx_drop_q <= 1'b1;
                    rx_lock_q <= 1'b1;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // receive store and read side
    // -----------------------------------------------------------------
    wire                     rx_skid_in_ready;
    wire                     rx_skid_out_valid;
    wire [`EFCF_SOF_BIT:0]   rx_skid_out_data;
    wire                     rx_rd_en;
    wire                     rx_out_take;
    reg                      rx_sof_pend_q;

    assign rx_rd_en    = rx_rd_avail & rx_skid_in_ready;
    assign rx_out_take = receive_valid_out_low | ~receive_accept_in_low;

    efcf_frame_store #(
        .DW (`EFCF_BYTE_W + 1),
        .AW (`EFCF_STORE_AW)
    ) u_rx_store (
        .clk        (clk_sys),
        .rst        (rst),
        .srst       (receive_user_sync_reset),
        .wr_en      (rx_wr_en),
        .wr_data    ({rx_mac_frame_good, rx_hold_q}),
        .wr_commit  (rx_commit),
        .wr_drop    (rx_discard),
        .rd_en      (rx_rd_en),
        .rd_release (rx_rd_en),
        .rd_rewind  (1'b0),
        .rd_data    (rx_rd_data),
        .rd_avail   (rx_rd_avail),
        .used       (rx_used),
        .full       (rx_full)
    );

    efcf_skid_fifo #(
        .W     (`EFCF_SOF_BIT + 1),
        .DEPTH (`EFCF_SKID_DEPTH),
        .AW    (`EFCF_SKID_AW)
    ) u_rx_skid (
        .clk       (clk_sys),
        .rst       (rst),
        .srst      (receive_user_sync_reset),
        .in_valid  (rx_rd_avail),
        .in_ready  (rx_skid_in_ready),
        .in_data   ({rx_sof_pend_q, rx_rd_data}),
        .out_valid (rx_skid_out_valid),
        .out_ready (rx_out_take),
        .out_data  (rx_skid_out_data)
    );

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_sof_pend_q            <= 1'b1;
            receive_user_byte_out    <= {`EFCF_BYTE_W{1'b0}};
            receive_first_marker_low <= 1'b1;
            receive_last_marker_low  <= 1'b1;
            receive_valid_out_low    <= 1'b1;
            rx_fifo_level            <= 4'h0;
        end
        else if (receive_user_sync_reset)
        begin
            rx_sof_pend_q            <= 1'b1;
            receive_user_byte_out    <= {`EFCF_BYTE_W{1'b0}};
            receive_first_marker_low <= 1'b1;
            receive_last_marker_low  <= 1'b1;
            receive_valid_out_low    <= 1'b1;
            rx_fifo_level            <= 4'h0;
        end
        else
        begin
            rx_fifo_level <= efcf_level(rx_used);
            if (rx_rd_en)
                rx_sof_pend_q <= rx_rd_data[`EFCF_EOF_BIT];
            if (rx_out_take)
            begin
                receive_valid_out_low    <= ~rx_skid_out_valid;
                receive_user_byte_out    <= rx_skid_out_data[`EFCF_BYTE_W-1:0];
                receive_first_marker_low <= ~rx_skid_out_data[`EFCF_SOF_BIT];
                receive_last_marker_low  <= ~rx_skid_out_data[`EFCF_EOF_BIT];
            end
        end
    end

    // -----------------------------------------------------------------
    // transmit write side
    // -----------------------------------------------------------------
    reg                      tx_ovf_mode_q;
    reg  [1:0]               tx_state_q;
    wire [`EFCF_STORE_AW:0]  tx_used;
    wire                     tx_full;
    wire                     tx_rd_avail;
    wire [`EFCF_BYTE_W:0]    tx_rd_data;
    wire                     tx_take;
    wire                     tx_last;
    wire                     tx_ovf_start;

    assign tx_take      = ~transmit_valid_in_low & ~transmit_accept_out_low;
    assign tx_last      = tx_take & ~transmit_last_marker_low;
    assign tx_ovf_start = tx_full & ~tx_rd_avail & (tx_state_q == TX_IDLE)
                          & ~tx_ovf_mode_q;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tx_ovf_mode_q           <= 1'b0;
            tx_overflow             <= 1'b0;
            transmit_accept_out_low <= 1'b1;
            tx_fifo_level           <= 4'h0;
        end
        else if (transmit_user_sync_reset)
        begin
            tx_ovf_mode_q           <= 1'b0;
            tx_overflow             <= 1'b0;
            transmit_accept_out_low <= 1'b1;
            tx_fifo_level           <= 4'h0;
        end
        else
        begin
            tx_fifo_level <= efcf_level(tx_used);
            tx_overflow   <= tx_ovf_start;
            if (tx_ovf_start)
                tx_ovf_mode_q <= 1'b1;
            else if (tx_last)
                tx_ovf_mode_q <= 1'b0;
            transmit_accept_out_low <= ~(tx_ovf_start | (tx_ovf_mode_q & ~tx_last)
                                       | (tx_used <= `EFCF_TX_ROOM_USED));
        end
    end

    // -----------------------------------------------------------------
    // transmit store
    // -----------------------------------------------------------------
    reg                      tx_last_q;
    reg                      tx_rd_en;
    reg                      tx_release;
    reg                      tx_rewind;

    efcf_frame_store #(
        .DW (`EFCF_BYTE_W + 1),
        .AW (`EFCF_STORE_AW)
    ) u_tx_store (
        .clk        (clk_sys),
        .rst        (rst),
        .srst       (transmit_user_sync_reset),
        .wr_en      (tx_take & ~tx_ovf_mode_q),
        .wr_data    ({tx_last, transmit_user_byte_in}),
        .wr_commit  (tx_last & ~tx_ovf_mode_q),
        .wr_drop    (tx_last & tx_ovf_mode_q),
        .rd_en      (tx_rd_en),
        .rd_release (tx_release),
        .rd_rewind  (tx_rewind),
        .rd_data    (tx_rd_data),
        .rd_avail   (tx_rd_avail),
        .used       (tx_used),
        .full       (tx_full)
    );

    // -----------------------------------------------------------------
    // transmit read side towards the mac
    // -----------------------------------------------------------------
    always @*
    begin
        tx_rd_en   = 1'b0;
        tx_release = 1'b0;
        tx_rewind  = 1'b0;
        case (tx_state_q)
            TX_IDLE:
                tx_rd_en = tx_rd_avail;
            TX_ACK, TX_SEND:
            begin
                if (tx_mac_collision)
                begin
                    tx_rewind  = tx_mac_retransmit;
                    tx_release = ~tx_mac_retransmit & tx_last_q;
                end
                else if (tx_state_q == TX_SEND || tx_mac_ack)
                begin
                    tx_rd_en   = ~tx_last_q;
                    tx_release = tx_last_q;
                end
            end
            TX_SKIP:
            begin
                tx_rd_en   = 1'b1;
                tx_release = tx_rd_data[`EFCF_EOF_BIT];
            end
            default:
                tx_rd_en = 1'b0;
        endcase
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tx_state_q        <= TX_IDLE;
            tx_last_q         <= 1'b0;
            tx_mac_byte       <= {`EFCF_BYTE_W{1'b0}};
            tx_mac_byte_valid <= 1'b0;
        end
        else if (transmit_user_sync_reset)
        begin
            tx_state_q        <= TX_IDLE;
            tx_last_q         <= 1'b0;
            tx_mac_byte       <= {`EFCF_BYTE_W{1'b0}};
            tx_mac_byte_valid <= 1'b0;
        end
        else
        begin
            if (tx_rd_en && tx_state_q != TX_SKIP)
            begin
                tx_mac_byte       <= tx_rd_data[`EFCF_BYTE_W-1:0];
                tx_last_q         <= tx_rd_data[`EFCF_EOF_BIT];
                tx_mac_byte_valid <= 1'b1;
            end
            case (tx_state_q)
                TX_IDLE:
                    if (tx_rd_avail)
                        tx_state_q <= TX_ACK;
                TX_ACK, TX_SEND:
                begin
                    if (tx_mac_collision)
                    begin
                        tx_mac_byte_valid <= 1'b0;
                        if (tx_mac_retransmit || tx_last_q)
                            tx_state_q <= TX_IDLE;
                        else
                            tx_state_q <= TX_SKIP;
                    end
                    else if (tx_release)
                    begin
                        tx_mac_byte_valid <= 1'b0;
                        tx_state_q        <= TX_IDLE;
                    end
                    else if (tx_mac_ack)
                        tx_state_q <= TX_SEND;
                end
                TX_SKIP:
                    if (tx_release)
                        tx_state_q <= TX_IDLE;
                default:
                    tx_state_q <= TX_IDLE;
            endcase
        end
    end

endmodule // efcf_top

// file: test/efcf_top_sva.sv
// assertions on the frame fifo pair ports
`timescale 1ns/100ps
module efcf_top_sva (
    input logic       clk_sys,
    input logic       rst,
    input logic       receive_user_sync_reset,
    input logic       transmit_user_sync_reset,
    input logic [7:0] receive_user_byte_out,
    input logic       receive_first_marker_low,
    input logic       receive_last_marker_low,
    input logic       receive_valid_out_low,
    input logic       receive_accept_in_low,
    input logic       rx_overflow,
    input logic       transmit_accept_out_low,
    input logic [3:0] tx_fifo_level,
    input logic       tx_overflow,
    input logic [7:0] tx_mac_byte,
    input logic       tx_mac_byte_valid,
    input logic       tx_mac_ack,
    input logic       tx_mac_collision,
    input logic       tx_mac_retransmit
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst || receive_user_sync_reset || transmit_user_sync_reset);
    sequence s_first_shown;
        $rose(tx_mac_byte_valid) && !tx_mac_ack && !tx_mac_collision;
    endsequence
    sequence s_replay;
        ##1 !tx_mac_byte_valid ##1 tx_mac_byte_valid;
    endsequence
    a_rx_stall_hold:
    assert property (!receive_valid_out_low && receive_accept_in_low |=> !receive_valid_out_low
        && $stable({receive_user_byte_out, receive_first_marker_low, receive_last_marker_low}))
        else $error("receive offer changed while stalled");
    a_rx_ovf_pulse:
    assert property (rx_overflow |=> !rx_overflow) else $error("receive overflow not a pulse");
    a_tx_ovf_pulse:
    assert property (tx_overflow |=> !tx_overflow) else $error("transmit overflow not a pulse");
    a_tx_first_hold:
    assert property (s_first_shown |=> tx_mac_byte_valid && $stable(tx_mac_byte))
        else $error("first transmit byte not held");
    a_tx_ack_stream:
    assert property (tx_mac_byte_valid && tx_mac_ack && !tx_mac_collision |=> tx_mac_byte_valid)
        else $error("transmit stream stopped after ack");
    a_tx_coll_stop:
    assert property (tx_mac_byte_valid && tx_mac_collision |=> !tx_mac_byte_valid)
        else $error("transmit not stopped by collision");
    a_tx_replay_start:
    assert property (tx_mac_byte_valid && tx_mac_collision && tx_mac_retransmit |-> s_replay)
        else $error("transmit frame not replayed");
    a_tx_room_accept:
    assert property (!$past(rst) && tx_fifo_level < 4'hf |=> !transmit_accept_out_low)
        else $error("transmit accept refused with room left");
endmodule // efcf_top_sva

bind efcf_top efcf_top_sva u_sva (.*);

// file: test/efcf_user_model.sv
// user reader model that stalls the receive accept
`timescale 1ns/100ps
module efcf_user_model (
    input  logic clk_sys,
    input  logic stall_en,
    output logic receive_accept_in_low
);
    integer seed = 32'h312b_68c8;
    initial receive_accept_in_low = 1'b1;
    // accept moves off the edge, random stalls, full stall on request
    always @(negedge clk_sys)
        receive_accept_in_low <= stall_en | (($random(seed) & 3) == 0);
endmodule // efcf_user_model

// file: test/efcf_top_bench.sv
// self-checking bench for the frame fifo pair
`timescale 1ns/100ps
module efcf_top_bench;
    logic       clk_sys = 0, rst = 1, srst = 1, stall_en = 0, hold_ack = 0, acked = 0;
    logic       rx_mac_byte_valid = 0, rx_mac_frame_good = 0, rx_mac_frame_bad = 0;
    logic       transmit_first_marker_low = 1, transmit_last_marker_low = 1;
    logic       transmit_valid_in_low = 1, tx_mac_ack = 0, tx_mac_collision = 0;
    logic       tx_mac_retransmit = 0;
    logic [7:0] rx_mac_byte = 0, transmit_user_byte_in = 0;
    logic [1:0] ovf = 0;
    logic [9:0] exp, rxq[$], txq[$];
    wire  [7:0] receive_user_byte_out, tx_mac_byte;
    wire  [3:0] rx_fifo_level, tx_fifo_level;
    wire        receive_first_marker_low, receive_last_marker_low, receive_valid_out_low;
    wire        receive_accept_in_low, rx_overflow, transmit_accept_out_low, tx_overflow;
    wire        tx_mac_byte_valid;
    wire        receive_user_sync_reset = srst;
    wire        transmit_user_sync_reset = srst;
    integer     seed = 32'h312b_68c8, fails = 0, comparisons = 0, cycles = 0, i, k;

    efcf_top u_dut (.*);
    efcf_user_model u_user (.*);
    always #20 clk_sys = ~clk_sys;

    task check(input string what, input logic [9:0] e, input logic [9:0] g);
        comparisons++;
        if (e !== g)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        ovf <= ovf | {rx_overflow, tx_overflow};
        if (!rst && !receive_valid_out_low && !receive_accept_in_low)
        begin
            exp = rxq.size() ? rxq.pop_front() : 10'h3ff;
            check("rx byte", exp, {receive_first_marker_low, receive_last_marker_low,
                receive_user_byte_out});
        end
        if (tx_mac_byte_valid && (tx_mac_ack || acked))
        begin
            acked <= 1;
            exp = txq.size() ? txq.pop_front() : 10'h3ff;
            check("tx byte", exp, {2'b00, tx_mac_byte});
        end
        else if (!tx_mac_byte_valid)
            acked <= 0;
        if (cycles > 30000)
        begin
            fails++;
            results;
        end
    end

    // mac acknowledges each shown first byte once
    always @(negedge clk_sys)
        tx_mac_ack <= tx_mac_byte_valid && !acked && !tx_mac_ack && !hold_ack;

    task rx_frame(input integer n, input logic good, input logic keep);
        for (i = 0; i < n; i++)
        begin
            rx_mac_byte = $random(seed);
            rx_mac_byte_valid = 1;
            if (keep)
                rxq.push_back({i != 0, i != n - 1, rx_mac_byte});
            @(negedge clk_sys);
        end
        rx_mac_byte_valid = 0;
        {rx_mac_frame_good, rx_mac_frame_bad} = {good, !good};
        @(negedge clk_sys);
        {rx_mac_frame_good, rx_mac_frame_bad} = 2'b00;
    endtask

    task tx_frame(input integer n, input logic keep);
        for (i = 0; i < n; i++)
        begin
            transmit_user_byte_in = $random(seed);
            transmit_first_marker_low = i != 0;
            transmit_last_marker_low = i != n - 1;
            transmit_valid_in_low = 0;
            do @(posedge clk_sys); while (transmit_accept_out_low);
            check("tx early", 0, {9'h0, tx_mac_byte_valid});
            if (i == 640)
                check("tx level", 2, {6'h0, tx_fifo_level});
            if (keep)
                txq.push_back({2'b00, transmit_user_byte_in});
            @(negedge clk_sys);
        end
        transmit_valid_in_low = 1;
    endtask

    task drain(input string what);
        i = 0;
        while ((rxq.size() || txq.size() || tx_mac_byte_valid || i < 40) && i < 2000)
        begin
            @(negedge clk_sys);
            i++;
        end
        check(what, 0, 10'(rxq.size() + txq.size()));
        $display("test %s done", what);
    endtask

    initial
    begin
        repeat (6) @(negedge clk_sys);
        {rst, srst} = 2'b00;
        check("rx level", 0, {6'h0, rx_fifo_level});
        repeat (4) rx_frame(2 + ($random(seed) & 63), 1, 1);
        rx_frame(20, 0, 0);
        stall_en = 1;
        rx_frame(4200, 1, 0);
        stall_en = 0;
        rx_frame(3, 1, 1);
        drain("rx");
        repeat (3)
        begin
            tx_frame(2 + ($random(seed) & 63), 1);
            drain("tx");
        end
        tx_frame(4200, 0);
        check("overflow", 3, {8'h0, ovf});
        for (k = 0; k < 3; k++)
        begin
            hold_ack = 1;
            tx_frame(9, k == 0);
            while (!tx_mac_byte_valid)
                @(negedge clk_sys);
            @(negedge clk_sys);
            {srst, tx_mac_collision, tx_mac_retransmit} = {k == 2, k < 2, k == 0};
            @(negedge clk_sys);
            {srst, tx_mac_collision, tx_mac_retransmit} = 3'b000;
            check("mac valid", 0, {9'h0, tx_mac_byte_valid});
            @(negedge clk_sys);
            hold_ack = 0;
            drain("replay");
        end
        results;
    end
endmodule // efcf_top_bench
